/* rtc_alarm.sv */
// Purpose: compares the three time bytes with the three alarm bytes
// Assumes: bytes are stable around the second tick
// Notes:   an alarm byte with both top bits set matches anything
`timescale 1ns/1ps
`include "rtc_map.svh"
module rtc_alarm
    import rtc_pkg::*;
(
    // compare link
    rtc_core_if.alm lnk
);
    logic [2:0] hit;

    for (genvar i = 0; i < 3; i++) begin : g_byte
        assign hit[i] = (lnk.alarm_b[i][7:6] == `RTC_DONT_CARE) ||
                        (lnk.alarm_b[i] == lnk.time_b[i]);
    end

    assign lnk.alarm_hit = &hit;
endmodule

/* rtc_core_if.sv */
// Purpose: links the control block to its divider tap and alarm compare
// Assumes: one clock domain
// Notes:   index 0 seconds, 1 minutes, 2 hours
`timescale 1ns/1ps
interface rtc_core_if;
    import rtc_pkg::*;
    rtc_rate_t rate_sel;
    logic      tap_level;
    logic      tap_fall;
    rtc_byte_t time_b  [3];
    rtc_byte_t alarm_b [3];
    logic      alarm_hit;

    modport ctl (output rate_sel, time_b, alarm_b, input tap_level, tap_fall, alarm_hit);
    modport div (input rate_sel, output tap_level, tap_fall);
    modport alm (input time_b, alarm_b, output alarm_hit);
endinterface

/* rtc_cpu_model.sv */
// Purpose: processor side of the rtc register port
// Assumes: one-cycle read and write strobes, read data registered on the taking edge and sampled 1 ns after it
// Notes:   address is scrambled after each access, write data after each write, so stale values never pass
`timescale 1ns/1ps
module rtc_cpu_model
    import rtc_pkg::*;
(
    // clock
    input  wire logic      core_clk,
    // register port
    output rtc_addr_t      reg_addr,
    output logic           reg_wr,
    output logic           reg_rd,
    output rtc_byte_t      reg_wdata,
    input  wire rtc_byte_t reg_rdata
);
    initial begin
        reg_addr  = 6'h00;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        reg_wdata = 8'h00;
    end

    task automatic wr(input rtc_addr_t a, input rtc_byte_t d);
        @(posedge core_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge core_clk);
        reg_wr    <= 1'b0;
        reg_addr  <= ~a;
        reg_wdata <= ~d;
    endtask

    // read has side effects, so strobe stays exactly one cycle
    task automatic rd(input rtc_addr_t a, output rtc_byte_t d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge core_clk);
        reg_rd   <= 1'b0;
        reg_addr <= ~a;
        #1;
        d = reg_rdata;
    endtask
endmodule

/* rtc_ctl.sv */
// Purpose: control, status and interrupt registers of a real-time clock
// Assumes: register port already decoded from the multiplexed bus
// Notes:   chip_clear_n is the pin reset, rst the core reset
//
// Behaviour
// - four-bit rate picks fifteen taps or off
// - one tap feeds periodic flag and square wave
// - rate bits change only by processor writes
// - inhibit bit aborts and blocks updates
// - periodic enable gates only the interrupt
// - alarm flag on three-byte match, 11 wildcard
// - alarm enable gates alarm interrupt, pin clears
// - update enable cleared by pin or inhibit
// - binary or bcd select, pin reset untouched
// - 24 or 12 hour select, software only
// - summer time enable, pin reset untouched
// - any flag is OR of gated flags
// - status read or pin clears periodic, alarm and update flags
// - periodic flag sets on selected tap edge
// - update done flag sets per update end unless inhibited
// - status low four bits read zero
// - valid flag: cleared by sense, set by read
// - valid register low seven bits zero
// - inhibit also clears update active
// - interrupt pin floats when no interrupt
`timescale 1ns/1ps
`include "rtc_map.svh"
module rtc_ctl
    import rtc_pkg::*;
#(
    parameter int DIV_W = 22
) (
    // clock and reset
    input  wire logic      core_clk,
    input  wire logic      rst,
    // device pins
    input  wire logic      chip_clear_n,
    input  wire logic      power_sense_in,
    output logic           square_out_pin,
    output logic           interrupt_out_n_out,
    output logic           interrupt_out_n_oe,
    // register port
    input  wire rtc_addr_t reg_addr,
    input  wire logic      reg_wr,
    input  wire logic      reg_rd,
    input  wire rtc_byte_t reg_wdata,
    output rtc_byte_t      reg_rdata,
    // time counters and update sequencer
    input  wire logic      second_tick,
    input  wire logic      update_start,
    input  wire logic      update_done,
    input  wire rtc_byte_t time_sec,
    input  wire rtc_byte_t time_min,
    input  wire rtc_byte_t time_hour,
    input  wire rtc_byte_t alarm_sec,
    input  wire rtc_byte_t alarm_min,
    input  wire rtc_byte_t alarm_hour,
    // controls to the counters
    output rtc_rate_t      rate_sel,
    output logic           update_inhibit,
    output logic           update_abort,
    output logic           binary_format_sel,
    output logic           hour_format_sel,
    output logic           summer_time_enable
);
    rtc_core_if lnk ();

    rtc_rate_t  rate_sel_reg;
    logic [2:0] div_sel_reg;
    logic       inhibit_reg;
    logic       pie_reg;
    logic       aie_reg;
    logic       uie_reg;
    logic       square_out_enable_reg;
    logic       dm_reg;
    logic       hour24_reg;
    logic       dse_reg;
    logic       periodic_flag_reg;
    logic       alarm_flag_reg;
    logic       update_done_flag_reg;
    logic       valid_contents_flag_reg;
    logic       update_active_reg;
    logic       abort_reg;
    logic       square_reg;
    logic       irq_oe_reg;
    rtc_byte_t  rdata_reg;
    rtc_byte_t  rdata_next;
    logic       any_irq_flag;
    logic       wr_rate;
    logic       wr_ctrl;
    logic       rd_flags;
    logic       rd_valid;
    logic       set_inhibit;
    logic       alarm_set;

    assign wr_rate     = reg_wr && (reg_addr == `RTC_OFS_RATE);
    assign wr_ctrl     = reg_wr && (reg_addr == `RTC_OFS_CTRL);
    assign rd_flags    = reg_rd && (reg_addr == `RTC_OFS_FLAGS);
    assign rd_valid    = reg_rd && (reg_addr == `RTC_OFS_VALID);
    assign set_inhibit = wr_ctrl && reg_wdata[`RTC_B_INHIBIT];
    assign alarm_set   = second_tick && lnk.alarm_hit;

    // sub blocks
    assign lnk.rate_sel   = rate_sel_reg;
    assign lnk.time_b[0]  = time_sec;
    assign lnk.time_b[1]  = time_min;
    assign lnk.time_b[2]  = time_hour;
    assign lnk.alarm_b[0] = alarm_sec;
    assign lnk.alarm_b[1] = alarm_min;
    assign lnk.alarm_b[2] = alarm_hour;

    rtc_divtap #(
        .DIV_W    (DIV_W)
    ) u_divtap (
        .core_clk (core_clk),
        .rst      (rst),
        .lnk      (lnk.div)
    );

    rtc_alarm u_alarm (
        .lnk (lnk.alm)
    );

    // rate and divider select: the pin reset leaves them alone
    always_ff @(posedge core_clk) begin
        if (rst) begin
            rate_sel_reg <= `RTC_RATE_OFF;
            div_sel_reg  <= '0;
        end else if (wr_rate) begin
            rate_sel_reg <= reg_wdata[`RTC_RATE_MSB:`RTC_RATE_LSB];
            div_sel_reg  <= reg_wdata[`RTC_DIVSEL_MSB:`RTC_DIVSEL_LSB];
        end
    end

    // format and mode bits, software only
    always_ff @(posedge core_clk) begin
        if (rst) begin
            inhibit_reg <= 1'b0;
            dm_reg      <= 1'b0;
            hour24_reg  <= 1'b0;
            dse_reg     <= 1'b0;
        end else if (wr_ctrl) begin
            inhibit_reg <= reg_wdata[`RTC_B_INHIBIT];
            dm_reg      <= reg_wdata[`RTC_B_DM];
            hour24_reg  <= reg_wdata[`RTC_B_HOUR24];
            dse_reg     <= reg_wdata[`RTC_B_DSE];
        end
    end

    // enables, cleared by the pin reset
    always_ff @(posedge core_clk) begin
        if (rst || !chip_clear_n) begin
            pie_reg  <= 1'b0;
            aie_reg  <= 1'b0;
            uie_reg  <= 1'b0;
            square_out_enable_reg <= 1'b0;
        end else if (wr_ctrl) begin
            pie_reg  <= reg_wdata[`RTC_B_PIE];
            aie_reg  <= reg_wdata[`RTC_B_AIE];
            // inhibit going high wins over a written enable
            uie_reg  <= reg_wdata[`RTC_B_UIE] && !(set_inhibit && !inhibit_reg);
            square_out_enable_reg <= reg_wdata[`RTC_B_SQUARE_OUT_ENABLE];
        end
    end

    // update sequencing status and abort pulse
    always_ff @(posedge core_clk) begin
        if (rst) begin
            update_active_reg <= 1'b0;
            abort_reg         <= 1'b0;
        end else begin
            abort_reg <= set_inhibit;
            if (set_inhibit || inhibit_reg || update_done) begin
                update_active_reg <= 1'b0;
            end else if (update_start) begin
                update_active_reg <= 1'b1;
            end
        end
    end

    // status flags: set wins over the read clear
    always_ff @(posedge core_clk) begin
        if (rst || !chip_clear_n) begin
            periodic_flag_reg    <= 1'b0;
            alarm_flag_reg       <= 1'b0;
            update_done_flag_reg <= 1'b0;
        end else begin
            periodic_flag_reg    <= (periodic_flag_reg && !rd_flags) || lnk.tap_fall;
            alarm_flag_reg       <= (alarm_flag_reg && !rd_flags) || alarm_set;
            update_done_flag_reg <= (update_done_flag_reg && !rd_flags) ||
                                    (update_done && !inhibit_reg);
        end
    end

    // valid contents flag ignores the pin reset
    always_ff @(posedge core_clk) begin
        if (rst || !power_sense_in) begin
            valid_contents_flag_reg <= 1'b0;
        end else if (rd_valid) begin
            valid_contents_flag_reg <= 1'b1;
        end
    end

    assign any_irq_flag = (periodic_flag_reg && pie_reg) ||
                          (alarm_flag_reg && aie_reg) ||
                          (update_done_flag_reg && uie_reg);

    // pins: open drain irq, square wave gated low
    always_ff @(posedge core_clk) begin
        if (rst || !chip_clear_n) begin
            irq_oe_reg <= 1'b0;
            square_reg <= 1'b0;
        end else begin
            irq_oe_reg <= any_irq_flag;
            square_reg <= square_out_enable_reg && lnk.tap_level;
        end
    end

    // read data, captured before any read side effect lands
    always_comb begin
        rdata_next = `RTC_ZERO_BYTE;
        case (reg_addr)
            `RTC_OFS_RATE: begin
                rdata_next[`RTC_RATE_MSB:`RTC_RATE_LSB]     = rate_sel_reg;
                rdata_next[`RTC_DIVSEL_MSB:`RTC_DIVSEL_LSB] = div_sel_reg;
                rdata_next[`RTC_B_UIP]                      = update_active_reg;
            end
            `RTC_OFS_CTRL: begin
                rdata_next[`RTC_B_INHIBIT] = inhibit_reg;
                rdata_next[`RTC_B_PIE]     = pie_reg;
                rdata_next[`RTC_B_AIE]     = aie_reg;
                rdata_next[`RTC_B_UIE]     = uie_reg;
                rdata_next[`RTC_B_SQUARE_OUT_ENABLE]    = square_out_enable_reg;
                rdata_next[`RTC_B_DM]      = dm_reg;
                rdata_next[`RTC_B_HOUR24]  = hour24_reg;
                rdata_next[`RTC_B_DSE]     = dse_reg;
            end
            `RTC_OFS_FLAGS: begin
                rdata_next[`RTC_B_ANY_IRQ_FLAG] = any_irq_flag;
                rdata_next[`RTC_B_PF]   = periodic_flag_reg;
                rdata_next[`RTC_B_AF]   = alarm_flag_reg;
                rdata_next[`RTC_B_UF]   = update_done_flag_reg;
            end
            `RTC_OFS_VALID: begin
                rdata_next[`RTC_B_VRT] = valid_contents_flag_reg;
            end
            default: begin
                rdata_next = `RTC_ZERO_BYTE;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            rdata_reg <= `RTC_ZERO_BYTE;
        end else if (reg_rd) begin
            rdata_reg <= rdata_next;
        end
    end

    // outputs
    assign reg_rdata           = rdata_reg;
    assign square_out_pin      = square_reg;
    assign interrupt_out_n_out = 1'b0;
    assign interrupt_out_n_oe  = irq_oe_reg;
    assign rate_sel            = rate_sel_reg;
    assign update_inhibit      = inhibit_reg;
    assign update_abort        = abort_reg;
    assign binary_format_sel   = dm_reg;
    assign hour_format_sel     = hour24_reg;
    assign summer_time_enable  = dse_reg;

    // checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    rate_hold_a: assert property (!wr_rate |=> $stable(rate_sel_reg))
        else $error("rate changed without a write");
    abort_pulse_a: assert property (set_inhibit |=> abort_reg && inhibit_reg
                                    && !update_active_reg)
        else $error("inhibit did not abort");
    pf_edge_a: assert property (lnk.tap_fall && chip_clear_n |=> periodic_flag_reg)
        else $error("periodic flag missed tap edge");
    alarm_set_a: assert property (alarm_set && chip_clear_n |=> alarm_flag_reg)
        else $error("alarm flag missed match");
    uie_clear_a: assert property (set_inhibit && !inhibit_reg |=> !uie_reg)
        else $error("update enable survived inhibit");
    enable_clear_a: assert property (!chip_clear_n |=> !pie_reg && !aie_reg && !square_out_enable_reg
                                     && !irq_oe_reg)
        else $error("pin reset left enables set");
    irq_pin_a: assert property (any_irq_flag && chip_clear_n |=> interrupt_out_n_oe)
        else $error("irq not driven");
    irq_float_a: assert property (!any_irq_flag |=> !interrupt_out_n_oe)
        else $error("irq driven without cause");
    read_clear_a: assert property (rd_flags && !lnk.tap_fall |=> !periodic_flag_reg)
        else $error("read did not clear flag");
    set_wins_a: assert property (rd_flags && update_done && !inhibit_reg && chip_clear_n
                                 |=> update_done_flag_reg)
        else $error("flag lost during read");
    low_bits_a: assert property (rd_flags |=> reg_rdata[3:0] == 4'h0)
        else $error("status low bits not zero");
    valid_low_a: assert property (rd_valid |=> reg_rdata[6:0] == 7'h00)
        else $error("valid register low bits not zero");
    vrt_sense_a: assert property (!power_sense_in |=> !valid_contents_flag_reg)
        else $error("valid flag set with sense low");
    sqw_low_a: assert property (!square_out_enable_reg |=> !square_out_pin)
        else $error("square pin not held low");

    // flags hold until a read or the pin clears them
    pf_hold_a: assert property (!rd_flags && chip_clear_n && periodic_flag_reg
                                |=> periodic_flag_reg)
        else $error("periodic flag lost without read");
    af_clear_a: assert property (rd_flags && !alarm_set |=> !alarm_flag_reg)
        else $error("read did not clear alarm flag");
    uf_clear_a: assert property (rd_flags && !update_done |=> !update_done_flag_reg)
        else $error("read did not clear update flag");
    uf_blocked_a: assert property (update_done && inhibit_reg && !update_done_flag_reg
                                   |=> !update_done_flag_reg)
        else $error("update flag set while inhibited");
    ua_clear_a: assert property (inhibit_reg |=> !update_active_reg)
        else $error("update active while inhibited");
    // mode bits move only on writes, never by logic
    mode_hold_a: assert property (!wr_ctrl |=> $stable({inhibit_reg, dm_reg, hour24_reg,
                                  dse_reg}))
        else $error("mode bits changed without a write");
    enable_hold_a: assert property (chip_clear_n && !wr_ctrl
                                    |=> $stable({pie_reg, aie_reg}))
        else $error("enable changed without a write");
    any_irq_flag_read_a: assert property (rd_flags
                                  |=> reg_rdata[`RTC_B_ANY_IRQ_FLAG] == $past(any_irq_flag))
        else $error("status read lost interrupt bit");
    vrt_set_a: assert property (rd_valid && power_sense_in |=> valid_contents_flag_reg)
        else $error("valid flag not set by read");
    sqw_follow_a: assert property (square_out_enable_reg && chip_clear_n
                                   |=> square_out_pin == $past(lnk.tap_level))
        else $error("square pin does not follow tap");

    periodic_irq_c: cover property (pie_reg && lnk.tap_fall ##2 interrupt_out_n_oe);
    alarm_irq_c: cover property (aie_reg && alarm_set ##1 rd_flags);
    valid_set_c: cover property (rd_valid && power_sense_in ##1 valid_contents_flag_reg);
    square_c: cover property (square_out_enable_reg && square_out_pin ##1 !square_out_pin);
    update_irq_c: cover property (uie_reg && update_done ##2 interrupt_out_n_oe);
endmodule

/* rtc_ctl_tb_top.sv */
// Purpose: self-checking bench of the rtc control block
// Assumes: full 22-bit divider, fastest rates used for tap timing
// Notes:   random stimulus from a fixed seed plus corner cases
`timescale 1ns/1ps
`include "rtc_map.svh"
module rtc_ctl_tb_top;
    import rtc_pkg::*;
    logic      core_clk, rst, chip_clear_n, power_sense_in;
    logic      square_out_pin, interrupt_out_n_out, interrupt_out_n_oe;
    rtc_addr_t reg_addr;
    logic      reg_wr, reg_rd;
    rtc_byte_t reg_wdata, reg_rdata;
    logic      second_tick, update_start, update_done;
    rtc_byte_t tm [3];
    rtc_byte_t al [3];
    rtc_rate_t rate_sel;
    logic      update_inhibit, update_abort;
    logic      binary_format_sel, hour_format_sel, summer_time_enable;
    int        fails, tests_run, cycles, i, j, p;
    integer    seed;
    rtc_byte_t d, c;
    logic      m;

    rtc_ctl #(.DIV_W(22)) u_rtc_ctl (
        .core_clk(core_clk), .rst(rst), .chip_clear_n(chip_clear_n),
        .power_sense_in(power_sense_in), .square_out_pin(square_out_pin),
        .interrupt_out_n_out(interrupt_out_n_out), .interrupt_out_n_oe(interrupt_out_n_oe),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .second_tick(second_tick), .update_start(update_start),
        .update_done(update_done), .time_sec(tm[0]), .time_min(tm[1]), .time_hour(tm[2]),
        .alarm_sec(al[0]), .alarm_min(al[1]), .alarm_hour(al[2]), .rate_sel(rate_sel),
        .update_inhibit(update_inhibit), .update_abort(update_abort),
        .binary_format_sel(binary_format_sel), .hour_format_sel(hour_format_sel),
        .summer_time_enable(summer_time_enable));

    rtc_cpu_model u_rtc_cpu_model (
        .core_clk(core_clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    task automatic print_verdict;
        if (fails == 0 && tests_run > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    // hang guard, well above the longest tap wait
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 40000) begin
            fails++;
            print_verdict();
        end
    end

    task automatic chk(input rtc_byte_t got, input rtc_byte_t exp);
        tests_run++;
        if (got !== exp) begin
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
            fails++;
        end
    endtask

    task automatic rdchk(input rtc_addr_t a, input rtc_byte_t exp);
        rtc_byte_t v;
        u_rtc_cpu_model.rd(a, v);
        chk(v, exp);
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    // 0 start, 1 done, 2 second, other pin clear
    task automatic pulse(input int k);
        @(posedge core_clk);
        case (k)
            0: update_start <= 1'b1;
            1: update_done <= 1'b1;
            2: second_tick <= 1'b1;
            default: chip_clear_n <= 1'b0;
        endcase
        @(posedge core_clk);
        update_start <= 1'b0;
        update_done  <= 1'b0;
        second_tick  <= 1'b0;
        chip_clear_n <= 1'b1;
    endtask

    // one clock at a time until the square pin shows lvl, 9000 in all at most
    task automatic wait_pin(input logic lvl, inout int n);
        while (square_out_pin !== lvl && n < 9000) begin
            tick(1);
            n++;
        end
    endtask

    // cycles between two rising edges of the square pin; the first rise
    // after a rate change may come early, so it is skipped
    task automatic meas(output int per);
        int k;
        k = 0;
        wait_pin(1'b0, k);
        wait_pin(1'b1, k);
        wait_pin(1'b0, k);
        wait_pin(1'b1, k);
        per = k;
        wait_pin(1'b0, k);
        wait_pin(1'b1, k);
        per = k - per;
    endtask

    function automatic int tap_period(input int n);
        return 1 << (22 - n);
    endfunction

    function automatic logic byte_hit(input rtc_byte_t t, input rtc_byte_t a);
        return (a[7:6] == 2'b11) || (a == t);
    endfunction

    initial begin
        seed = 32'h754e;
        fails = 0;
        tests_run = 0;
        cycles = 0;
        rst = 1'b1;
        chip_clear_n = 1'b1;
        power_sense_in = 1'b0;
        second_tick = 1'b0;
        update_start = 1'b0;
        update_done = 1'b0;
        for (i = 0; i < 3; i++) begin tm[i] = 8'h00; al[i] = 8'h01; end
        repeat (8) @(posedge core_clk);
        rst <= 1'b0;
        rdchk(`RTC_OFS_CTRL, 8'h00);
        rdchk(`RTC_OFS_FLAGS, 8'h00);
        // round trips, then the pin clear keeps only mode and rate bits
        for (i = 0; i < 4; i++) begin
            d = $random(seed);
            c = $random(seed) & 8'h7f;
            u_rtc_cpu_model.wr(`RTC_OFS_RATE, d);
            rdchk(`RTC_OFS_RATE, {1'b0, d[6:0]});
            chk({4'h0, rate_sel}, {4'h0, d[3:0]});
            u_rtc_cpu_model.wr(`RTC_OFS_CTRL, c);
            rdchk(`RTC_OFS_CTRL, c);
            chk({5'h0, binary_format_sel, hour_format_sel, summer_time_enable},
                {5'h0, c[2:0]});
            pulse(3);
            rdchk(`RTC_OFS_RATE, {1'b0, d[6:0]});
            rdchk(`RTC_OFS_CTRL, c & 8'h87);
        end
        // unmapped and read-only places ignore writes
        u_rtc_cpu_model.wr(`RTC_OFS_RATE, 8'h00);
        u_rtc_cpu_model.wr(6'h3f, 8'hff);
        u_rtc_cpu_model.wr(`RTC_OFS_FLAGS, 8'hff);
        u_rtc_cpu_model.rd(`RTC_OFS_FLAGS, d);
        rdchk(6'h3f, 8'h00);
        rdchk(`RTC_OFS_FLAGS, 8'h00);
        // inhibit aborts, drops update enable and update active
        u_rtc_cpu_model.wr(`RTC_OFS_CTRL, 8'h10);
        pulse(0);
        rdchk(`RTC_OFS_RATE, 8'h80);
        u_rtc_cpu_model.wr(`RTC_OFS_CTRL, 8'h97);
        #1;
        chk({6'h0, update_abort, update_inhibit}, 8'h03);
        tick(1);
        chk({7'h0, update_abort}, 8'h00);
        rdchk(`RTC_OFS_CTRL, 8'h87);
        rdchk(`RTC_OFS_RATE, 8'h00);
        pulse(1);
        rdchk(`RTC_OFS_FLAGS, 8'h00);
        // update done flag, interrupt pin and read clear
        u_rtc_cpu_model.wr(`RTC_OFS_CTRL, 8'h10);
        pulse(1);
        tick(3);
        chk({6'h0, interrupt_out_n_oe, interrupt_out_n_out}, 8'h02);
        rdchk(`RTC_OFS_FLAGS, 8'h90);
        tick(2);
        chk({7'h0, interrupt_out_n_oe}, 8'h00);
        rdchk(`RTC_OFS_FLAGS, 8'h00);
        // a flag setting during the read survives it
        u_rtc_cpu_model.wr(`RTC_OFS_CTRL, 8'h00);
        fork
            rdchk(`RTC_OFS_FLAGS, 8'h00);
            pulse(1);
        join
        rdchk(`RTC_OFS_FLAGS, 8'h10);
        pulse(1);
        pulse(3);
        rdchk(`RTC_OFS_FLAGS, 8'h00);
        // alarm compare with wildcards, enable on odd trials
        for (i = 0; i < 12; i++) begin
            c = i[0] ? 8'h20 : 8'h00;
            u_rtc_cpu_model.wr(`RTC_OFS_CTRL, c);
            m = 1'b1;
            for (j = 0; j < 3; j++) begin
                c = $random(seed) & 8'h3f;
                d = $random(seed);
                // first two trials match exactly, without and with the enable
                if (i < 2) d[1:0] = 2'h2;
                tm[j] <= c;
                case (d[1:0])
                    2'h0: al[j] <= 8'hc0 | d;
                    2'h1: al[j] <= ($random(seed) & 8'h3f) ^ 8'h01;
                    default: al[j] <= c;
                endcase
            end
            tick(2);
            for (j = 0; j < 3; j++) m = m & byte_hit(tm[j], al[j]);
            pulse(2);
            tick(2);
            rdchk(`RTC_OFS_FLAGS, {m & i[0], 1'b0, m, 5'h00});
        end
        // tap rates on the square pin, periodic flag without its enable
        u_rtc_cpu_model.wr(`RTC_OFS_CTRL, 8'h08);
        for (i = 13; i < 16; i++) begin
            u_rtc_cpu_model.wr(`RTC_OFS_RATE, i[7:0]);
            meas(p);
            chk(p[15:8], 8'(tap_period(i) >> 8));
            chk(p[7:0], 8'(tap_period(i) & 8'hff));
            rdchk(`RTC_OFS_FLAGS, 8'h40);
        end
        u_rtc_cpu_model.wr(`RTC_OFS_CTRL, 8'h40);
        tick(tap_period(15) + 8);
        chk({7'h0, interrupt_out_n_oe}, 8'h01);
        chk({7'h0, square_out_pin}, 8'h00);
        rdchk(`RTC_OFS_FLAGS, 8'hc0);
        u_rtc_cpu_model.wr(`RTC_OFS_RATE, 8'h00);
        // a stray tap edge from the rate change lands before the clearing read
        tick(4);
        u_rtc_cpu_model.rd(`RTC_OFS_FLAGS, d);
        tick(600);
        rdchk(`RTC_OFS_FLAGS, 8'h00);
        // valid flag set by read with sense high, cleared by sense low
        rdchk(`RTC_OFS_VALID, 8'h00);
        power_sense_in <= 1'b1;
        u_rtc_cpu_model.rd(`RTC_OFS_VALID, d);
        rdchk(`RTC_OFS_VALID, 8'h80);
        u_rtc_cpu_model.wr(`RTC_OFS_VALID, 8'h7f);
        pulse(3);
        rdchk(`RTC_OFS_VALID, 8'h80);
        power_sense_in <= 1'b0;
        tick(2);
        rdchk(`RTC_OFS_VALID, 8'h00);
        print_verdict();
    end
endmodule

/* rtc_divtap.sv */
// Purpose: divider chain with rate tap selection
// Assumes: the chain advances every core clock
// Notes:   rate n picks divider bit tap_lsb + 15 - n; rate 0 stops the tap
`timescale 1ns/1ps
`include "rtc_map.svh"
module rtc_divtap
    import rtc_pkg::*;
#(
    parameter int DIV_W = 22
) (
    // clock and reset
    input  wire logic core_clk,
    input  wire logic rst,
    // tap link
    rtc_core_if.div   lnk
);
    logic [DIV_W-1:0] div_reg;
    logic [4:0]       tap_idx;
    logic             tap_next;
    logic             tap_reg;
    logic             fall_reg;

    // 15 taps or off, one tap feeds both users
    assign tap_idx  = 5'(`RTC_TAP_LSB + `RTC_RATE_TOP - {1'b0, lnk.rate_sel});
    assign tap_next = (lnk.rate_sel != `RTC_RATE_OFF) && div_reg[tap_idx];

    always_ff @(posedge core_clk) begin
        if (rst) begin
            div_reg <= '0;
        end else begin
            div_reg <= div_reg + 1'b1;
        end
    end

    // falling edge marks a period; a rate change may add one early edge
    always_ff @(posedge core_clk) begin
        if (rst) begin
            tap_reg  <= 1'b0;
            fall_reg <= 1'b0;
        end else begin
            tap_reg  <= tap_next;
            fall_reg <= tap_reg && !tap_next;
        end
    end

    assign lnk.tap_level = tap_reg;
    assign lnk.tap_fall  = fall_reg;
endmodule

/* rtc_map.svh */
// Purpose: register offsets, bit positions and reset values of the rtc control block
// Assumes: 6-bit register index, 8-bit register data
// Notes:   definitions only
`ifndef RTC_CTL_MAP_SVH
`define RTC_CTL_MAP_SVH

`define RTC_OFS_RATE      6'h0a
`define RTC_OFS_CTRL      6'h0b
`define RTC_OFS_FLAGS     6'h0c
`define RTC_OFS_VALID     6'h0d

`define RTC_B_INHIBIT     3'h7
`define RTC_B_PIE         3'h6
`define RTC_B_AIE         3'h5
`define RTC_B_UIE         3'h4
`define RTC_B_SQUARE_OUT_ENABLE        3'h3
`define RTC_B_DM          3'h2
`define RTC_B_HOUR24      3'h1
`define RTC_B_DSE         3'h0

`define RTC_B_ANY_IRQ_FLAG        3'h7
`define RTC_B_PF          3'h6
`define RTC_B_AF          3'h5
`define RTC_B_UF          3'h4
`define RTC_B_VRT         3'h7
`define RTC_B_UIP         3'h7

`define RTC_RATE_LSB      2'h0
`define RTC_RATE_MSB      2'h3
`define RTC_DIVSEL_LSB    3'h4
`define RTC_DIVSEL_MSB    3'h6

`define RTC_ZERO_BYTE     8'h00
`define RTC_RATE_OFF      4'h0
`define RTC_RATE_TOP      5'h0f
`define RTC_TAP_LSB       5'h06
`define RTC_DONT_CARE     2'h3

`endif

/* rtc_pkg.sv */
// Purpose: shared types of the rtc control block
// Assumes: nothing beyond the map header
// Notes:   constants live in rtc_map.svh
package rtc_pkg;
    typedef logic [7:0] rtc_byte_t;
    typedef logic [3:0] rtc_rate_t;
    typedef logic [5:0] rtc_addr_t;
endpackage
